// [logic/spims_core.sv]
// Purpose: Master/slave serial controller with 1/2/4-bit data lines.
// Assumes: APB master on pclk; pins are asynchronous to pclk.
// Notes: Slave pin inputs pass two flip-flops before use.
// What this block does
// - Direction bit 15 makes multi-bit lines outputs when 0, inputs when 1.
// - Bus width 00 one line, 01 two lines, 10 or 11 four lines.
// - Early bit 12 interrupts when data can be taken, else at the end.
// - Buffered receive mode interrupts on buffer full or select end.
// - Slave select mode 00 interrupted, 10 falling edge, 11 rising edge.
// - Bit 5 set selects master, clear selects slave.
// - Word length is the length field plus one.
// - Idle master drives frame sync at the idle level of bit 0.
// - Master clock is pclk over two times divider plus one.
// - Default edges sample on rise, change on fall; phase swaps them.
// - Phase clear presents first bit at select; set presents at edge one.
// - Slave break flag on select loss or new start mid word; sticky.
// - Overrun flag when a received word overwrites unread data; sticky.
// - Status shows receive pending, transmit pending, shifter running.
// - Slave underrun flag when a transfer starts without data; sticky.
// - Data writes only while transmit pending clear, or into the second buffer when bit 8 is set; master write starts.
// - Write sets pending unless the shifter is idle and takes it at once.
// - Slave shifts only on clocks the external master provides.
// - Data reads return the word in low bits, upper bits zero.
// - Frame sync value shifts out aligned with its data word; a slave with phase clear holds the idle level for the first bit.
// - Frame sync value is double buffered like the data.
// - Interrupt on break set, transmit pending clear or shifter stop.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module spims_core
  import spims_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // Chip select pin
  input wire logic cs_n_i,
  output logic cs_n_o,
  output logic cs_n_oe,
  // Data lines: 0 slave out, 1 master out, 2 and 3 extra lines
  input wire logic [3:0] dat_i,
  output logic [3:0] dat_o,
  output logic [3:0] dat_oe,
  // Frame sync and interrupt
  output logic frame_sync_out,
  output logic irq
);
  function automatic logic [2:0] lanes(input logic [1:0] bm);
    lanes = (bm == BUS_1) ? 3'd1 : (bm == BUS_2) ? 3'd2 : 3'd4;
  endfunction

  function automatic logic [4:0] steps(input logic [3:0] l,
                                       input logic [2:0] k);
    logic [4:0] n;
    n = {1'b0, l} + 5'd1;
    if (k == 3'd1)
      steps = n;
    else if (k == 3'd2)
      steps = {1'b0, n[4:1]} + {4'd0, n[0]};
    else
      steps = {2'b00, n[4:2]} + {4'd0, |n[1:0]};
  endfunction

  // Left-justify a word so its first bit sits at bit 15.
  function automatic logic [15:0] align(input logic [15:0] v,
                                        input logic [3:0] l);
    align = v << (4'd15 - l);
  endfunction

  function automatic logic [3:0] outb(input logic [15:0] s,
                                      input logic [2:0] k,
                                      input logic m);
    if (k == 3'd1)
      outb = m ? {2'b00, s[15], 1'b0} : {3'b000, s[15]};
    else if (k == 3'd2)
      outb = {2'b00, s[15:14]};
    else
      outb = s[15:12];
  endfunction

  logic [15:0] cfg_q, fs_last_q;
  logic [9:0] ccf_q;
  logic master, srst, cpol, cpha, ddr, rxfen, txfen;
  logic [1:0] csm;
  logic [3:0] len;
  logic [2:0] w;
  logic [4:0] nsteps;
  logic [15:0] lmask;
  assign master = cfg_q[CF_MASTER];
  assign srst = cfg_q[CF_SRST];
  assign ddr = cfg_q[CF_DDR];
  assign rxfen = cfg_q[CF_RXFEN];
  assign txfen = cfg_q[CF_TXFEN];
  assign csm = cfg_q[CF_CSM_HI:CF_CSM_LO];
  assign len = cfg_q[CF_LEN_HI:CF_LEN_LO];
  assign cpol = ccf_q[CC_POL];
  assign cpha = ccf_q[CC_PHA];
  assign w = lanes(cfg_q[CF_BUS_HI:CF_BUS_LO]);
  assign nsteps = steps(len, w);
  assign lmask = 16'hffff >> (4'd15 - len);

  // Pin synchronisers; the third stage only feeds edge detection.
  logic [5:0] sy1_q, sy2_q;
  logic sck_s3_q, cs_s3_q, sck_s, cs_s;
  logic [3:0] din;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy1_q <= SYNC_RST;
      sy2_q <= SYNC_RST;
      sck_s3_q <= 1'b0;
      cs_s3_q <= 1'b1;
    end
    else
    begin
      sy1_q <= {sck_i, cs_n_i, dat_i};
      sy2_q <= sy1_q;
      sck_s3_q <= sy2_q[5];
      cs_s3_q <= sy2_q[4];
    end
  end
  assign sck_s = sy2_q[5];
  assign cs_s = sy2_q[4];
  assign din = sy2_q[3:0];

  // APB slave: zero wait states, error on unmapped or misaligned address.
  logic [5:0] idx;
  logic setup, acc, hit, wr, wr_cfg, wr_stat, wr_dat, rd_pop;
  logic [31:0] rd_mux;
  logic [7:0] stat;
  logic [15:0] rx_data_q;
  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign hit = (paddr[1:0] == 2'b00) && (idx <= IDX_FS);
  assign wr = acc && pwrite && !pslverr;
  assign wr_cfg = wr && (idx == IDX_CFG);
  assign wr_stat = wr && (idx == IDX_STAT);
  assign wr_dat = wr && (idx == IDX_DATA);
  assign rd_pop = acc && !pwrite && !pslverr && (idx == IDX_DATA);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_CFG: rd_mux[15:0] = cfg_q;
      IDX_CLK: rd_mux[9:0] = ccf_q;
      IDX_STAT: rd_mux[7:0] = stat;
      IDX_DATA: rd_mux[15:0] = rx_data_q;
      IDX_FS: rd_mux[15:0] = fs_last_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup)
        prdata <= hit ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= CFG_RST;
      ccf_q <= CC_RST;
      fs_last_q <= FS_RST;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= pwdata[15:0];
      if (wr && idx == IDX_CLK)
        ccf_q <= pwdata[9:0];
      if (wr && idx == IDX_FS)
        fs_last_q <= pwdata[15:0];
    end
  end

  // Shift engine.
  spims_eng_t st_q;
  logic [15:0] txs_q, fss_q, rxs_q, rx_next, rx_word;
  logic [15:0] tx_hold_q, fs_hold_q, txf_q, fsf_q;
  logic [5:0] cnt_q;
  logic lead_q, loaded_q, tx_full_q, txff_q, tick;
  logic edge_ev, lead_ev, smp, chg, wend, take, midword;
  logic cs_fall, cs_rise, s_start, s_stop, brk_set, urun_set;
  logic running;

  spims_tick_gen #(.DW(DIV_W)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(master && st_q == ENG_RUN),
    .div(ccf_q[CC_DIV_HI:CC_DIV_LO]),
    .tick(tick)
  );

  assign cs_fall = cs_s3_q && !cs_s;
  assign cs_rise = !cs_s3_q && cs_s;
  assign s_start = !master && ((csm == CSM_RISE) ? cs_rise : cs_fall);
  assign s_stop = !master && !csm[1] && cs_rise;
  assign midword = st_q == ENG_RUN && cnt_q != {1'b0, nsteps};
  assign brk_set = midword && (s_stop || (s_start && csm[1]));
  assign urun_set = s_start && !loaded_q;
  assign edge_ev = master ? (tick && st_q == ENG_RUN)
                 : (st_q == ENG_RUN && sck_s != sck_s3_q);
  assign lead_ev = master ? lead_q : (sck_s ^ cpol);
  assign smp = edge_ev && (lead_ev ^ cpha);
  assign chg = edge_ev && !(lead_ev ^ cpha);
  assign wend = edge_ev && cnt_q == 6'd1 && (master || smp);
  assign take = tx_full_q && (wend || (st_q == ENG_IDLE && !loaded_q));
  assign running = loaded_q || st_q == ENG_RUN;

  always_comb
  begin
    if (w == 3'd1)
      rx_next = {rxs_q[14:0], master ? din[0] : din[1]};
    else if (w == 3'd2)
      rx_next = {rxs_q[13:0], din[1:0]};
    else
      rx_next = {rxs_q[11:0], din};
  end
  assign rx_word = (smp ? rx_next : rxs_q) & lmask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ENG_IDLE;
      txs_q <= 16'h0000;
      fss_q <= 16'h0000;
      rxs_q <= 16'h0000;
      tx_hold_q <= 16'h0000;
      fs_hold_q <= 16'h0000;
      txf_q <= 16'h0000;
      fsf_q <= 16'h0000;
      cnt_q <= 6'd0;
      lead_q <= 1'b0;
      loaded_q <= 1'b0;
      tx_full_q <= 1'b0;
      txff_q <= 1'b0;
      sck_o <= 1'b0;
      cs_n_o <= 1'b1;
      dat_o <= 4'h0;
      frame_sync_out <= 1'b0;
    end
    else if (srst)
    begin
      st_q <= ENG_IDLE;
      cnt_q <= 6'd0;
      loaded_q <= 1'b0;
      tx_full_q <= 1'b0;
      txff_q <= 1'b0;
      sck_o <= cpol;
      cs_n_o <= 1'b1;
      frame_sync_out <= cfg_q[CF_FSIDLE];
    end
    else
    begin
      if (st_q == ENG_IDLE)
      begin
        sck_o <= cpol;
        cs_n_o <= 1'b1;
        frame_sync_out <= cfg_q[CF_FSIDLE];
      end
      if (master && edge_ev)
      begin
        sck_o <= !sck_o;
        lead_q <= !lead_q;
      end
      if (master ? edge_ev : smp)
        cnt_q <= cnt_q - 6'd1;
      if (smp)
        rxs_q <= rx_next;
      if (chg)
      begin
        dat_o <= outb(txs_q, w, master);
        txs_q <= txs_q << w;
        frame_sync_out <= fss_q[15];
        fss_q <= fss_q << 1;
      end
      if (take)
      begin
        txs_q <= tx_hold_q;
        fss_q <= fs_hold_q;
        loaded_q <= 1'b1;
        tx_hold_q <= txf_q;
        fs_hold_q <= fsf_q;
        tx_full_q <= txff_q;
        txff_q <= 1'b0;
      end
      else if (wend)
        loaded_q <= 1'b0;
      if (wend)
      begin
        cnt_q <= master ? {nsteps, 1'b0} : {1'b0, nsteps};
        lead_q <= 1'b1;
        if (!cpha)
        begin
          dat_o <= outb(tx_hold_q, w, master);
          txs_q <= tx_hold_q << w;
          frame_sync_out <= master ? fs_hold_q[15] : frame_sync_out;
          fss_q <= fs_hold_q << 1;
        end
        if (master ? !tx_full_q : csm[1])
        begin
          st_q <= ENG_IDLE;
          cs_n_o <= master ? 1'b1 : cs_n_o;
        end
      end
      if (master && st_q == ENG_IDLE && loaded_q)
      begin
        st_q <= ENG_RUN;
        cs_n_o <= 1'b0;
        cnt_q <= {nsteps, 1'b0};
        lead_q <= 1'b1;
        rxs_q <= 16'h0000;
      end
      if (s_start)
      begin
        st_q <= ENG_RUN;
        cnt_q <= {1'b0, nsteps};
      end
      if ((master && st_q == ENG_IDLE && loaded_q) || s_start)
      begin
        if (!cpha)
        begin
          dat_o <= outb(txs_q, w, master);
          txs_q <= txs_q << w;
          frame_sync_out <= master ? fss_q[15] : frame_sync_out;
          fss_q <= fss_q << 1;
        end
      end
      if (s_stop)
        st_q <= ENG_IDLE;
      if (wr_dat)
      begin
        if (!loaded_q && st_q == ENG_IDLE && !tx_full_q)
        begin
          txs_q <= align(pwdata[15:0], len);
          fss_q <= align(fs_last_q, len);
          loaded_q <= 1'b1;
        end
        else if (!tx_full_q || (take && !txff_q))
        begin
          tx_hold_q <= align(pwdata[15:0], len);
          fs_hold_q <= align(fs_last_q, len);
          tx_full_q <= 1'b1;
        end
        else if (txfen && (!txff_q || take))
        begin
          txf_q <= align(pwdata[15:0], len);
          fsf_q <= align(fs_last_q, len);
          txff_q <= 1'b1;
        end
      end
    end
  end

  // Multi-bit lines are driven only in transmit direction.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_oe <= 1'b0;
      cs_n_oe <= 1'b0;
      dat_oe <= 4'h0;
    end
    else
    begin
      sck_oe <= master;
      cs_n_oe <= master;
      if (w == 3'd1)
        dat_oe <= master ? 4'b0010 : {3'b000, st_q == ENG_RUN};
      else if (ddr || (!master && st_q != ENG_RUN))
        dat_oe <= 4'h0;
      else
        dat_oe <= (w == 3'd2) ? 4'b0011 : 4'b1111;
    end
  end

  // Receive side and status flags.
  logic [15:0] rxf_q, rxd_d, rxf_d;
  logic rx_full_q, rxff_q, rxfull_d, rxff_d, orun_set;
  logic brk_q, orun_q, urun_q, tx_full_p_q, run_p_q, rx_irq;
  always_comb
  begin
    rxd_d = rx_data_q;
    rxf_d = rxf_q;
    rxfull_d = rx_full_q;
    rxff_d = rxff_q;
    orun_set = 1'b0;
    if (rd_pop && rx_full_q)
    begin
      rxd_d = rxf_q;
      rxfull_d = rxff_q;
      rxff_d = 1'b0;
    end
    if (wend)
    begin
      if (!rxfull_d)
      begin
        rxd_d = rx_word;
        rxfull_d = 1'b1;
      end
      else if (rxfen && !rxff_d)
      begin
        rxf_d = rx_word;
        rxff_d = 1'b1;
      end
      else
      begin
        orun_set = 1'b1;
        if (rxff_d)
          rxf_d = rx_word;
        else
          rxd_d = rx_word;
      end
    end
  end
  assign rx_irq = cfg_q[CF_RXFMODE]
    ? ((rxff_d && !rxff_q) || (s_stop && rx_full_q)) : wend;
  assign stat = {rxff_q, txff_q, brk_q, orun_q, rx_full_q, tx_full_q,
                 running, urun_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_data_q <= 16'h0000;
      rxf_q <= 16'h0000;
      rx_full_q <= 1'b0;
      rxff_q <= 1'b0;
      brk_q <= 1'b0;
      orun_q <= 1'b0;
      urun_q <= 1'b0;
      tx_full_p_q <= 1'b0;
      run_p_q <= 1'b0;
      irq <= 1'b0;
    end
    else if (srst)
    begin
      rx_full_q <= 1'b0;
      rxff_q <= 1'b0;
      brk_q <= 1'b0;
      orun_q <= 1'b0;
      urun_q <= 1'b0;
      tx_full_p_q <= 1'b0;
      run_p_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      rx_data_q <= rxd_d;
      rxf_q <= rxf_d;
      rx_full_q <= rxfull_d;
      rxff_q <= rxff_d;
      brk_q <= brk_set || (brk_q && !(wr_stat && pwdata[ST_BRK]));
      orun_q <= orun_set
             || (orun_q && !(wr_stat && pwdata[ST_ORUN]));
      urun_q <= urun_set
             || (urun_q && !(wr_stat && pwdata[ST_URUN]));
      tx_full_p_q <= tx_full_q;
      run_p_q <= running;
      irq <= (brk_set && !brk_q) || rx_irq
          || (run_p_q && !running)
          || (cfg_q[CF_EARLY] && tx_full_p_q && !tx_full_q);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence m_start_s;
    master && st_q == ENG_IDLE && loaded_q && !srst && !wr_cfg;
  endsequence

  direct_load_a: assert property (
    wr_dat && !loaded_q && st_q == ENG_IDLE && !tx_full_q && !srst
    |=> loaded_q && !tx_full_q)
    else $error("idle write did not go straight to the shifter");
  frame_sync_out_idle_a: assert property (
    $past(master && st_q == ENG_IDLE && !srst) && master
    && st_q == ENG_IDLE |-> frame_sync_out == $past(cfg_q[CF_FSIDLE]))
    else $error("idle frame sync not at idle level");
  brk_hold_a: assert property (
    brk_q && !srst && !(wr_stat && pwdata[ST_BRK]) |=> brk_q)
    else $error("break flag cleared without software");
  overrun_a: assert property (
    wend && rx_full_q && !rd_pop && (!rxfen || rxff_q) && !srst
    |=> orun_q)
    else $error("overrun not flagged");
  rx_mask_a: assert property (
    rx_full_q && $stable(cfg_q) |-> (rx_data_q & ~lmask) == 16'h0000)
    else $error("received word has bits above the word length");
  master_len_a: assert property (
    m_start_s |=> st_q == ENG_RUN && cnt_q == {$past(nsteps), 1'b0})
    else $error("master transfer length wrong");
  irq_brk_a: assert property (
    brk_set && !brk_q && !srst |=> irq ##1 brk_q)
    else $error("no interrupt on break");
  urun_a: assert property (
    urun_set && !srst |=> urun_q)
    else $error("underrun not flagged");
  ddr_rx_a: assert property (
    $past(ddr && w != 3'd1 && !srst) |-> dat_oe == 4'h0)
    else $error("data lines driven in receive direction");
endmodule

// [logic/spims_pkg.sv]
// Purpose: Shared constants and types of the serial controller.
// Assumes: Registers sit on a 32-bit APB, one aligned word each.
// Notes: Byte address of a register is four times its index.
package spims_pkg;
  // Register indices; the byte address is the index times four.
  localparam logic [5:0] IDX_CFG = 6'h00;
  localparam logic [5:0] IDX_CLK = 6'h01;
  localparam logic [5:0] IDX_STAT = 6'h02;
  localparam logic [5:0] IDX_DATA = 6'h03;
  localparam logic [5:0] IDX_FS = 6'h04;
  // Main configuration fields.
  localparam int CF_DDR = 15;
  localparam int CF_BUS_HI = 14;
  localparam int CF_BUS_LO = 13;
  localparam int CF_EARLY = 12;
  localparam int CF_SRST = 11;
  localparam int CF_RXFMODE = 10;
  localparam int CF_RXFEN = 9;
  localparam int CF_TXFEN = 8;
  localparam int CF_CSM_HI = 7;
  localparam int CF_CSM_LO = 6;
  localparam int CF_MASTER = 5;
  localparam int CF_LEN_HI = 4;
  localparam int CF_LEN_LO = 1;
  localparam int CF_FSIDLE = 0;
  // Clock configuration fields.
  localparam int CC_DIV_HI = 9;
  localparam int CC_DIV_LO = 2;
  localparam int CC_POL = 1;
  localparam int CC_PHA = 0;
  // Status bits.
  localparam int ST_BRK = 5;
  localparam int ST_ORUN = 4;
  localparam int ST_URUN = 0;
  // Reset values.
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [9:0] CC_RST = 10'h000;
  localparam logic [15:0] FS_RST = 16'h0000;
  localparam logic [5:0] SYNC_RST = 6'h10;
  // Field encodings.
  localparam logic [1:0] BUS_1 = 2'b00;
  localparam logic [1:0] BUS_2 = 2'b01;
  localparam logic [1:0] CSM_FALL = 2'b10;
  localparam logic [1:0] CSM_RISE = 2'b11;
  localparam int DIV_W = 8;
  typedef enum logic {ENG_IDLE, ENG_RUN} spims_eng_t;
endpackage

// [logic/spims_tick_gen.sv]
// Purpose: Half-period strobe for the generated serial clock.
// Assumes: div is steady while run is high.
// Notes: One strobe every div+1 cycles, so the clock is pclk/(2(div+1)).
`timescale 1ns/1ps
module spims_tick_gen
  import spims_pkg::*;
#(
  parameter int DW = DIV_W
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [DW-1:0] div,
  // Strobe
  output logic tick
);
  logic [DW-1:0] cnt_q;
  logic [DW-1:0] gap_q;
  logic seen_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q == div)
    begin
      cnt_q <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end

  // Cycles since the last strobe, read only by the check below.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q <= (tick || !run) ? '0 : gap_q + 1'b1;
      seen_q <= run && (seen_q || tick);
    end
  end

  tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && seen_q && $past(run) && $stable(div)) |-> gap_q == div)
    else $error("serial clock half period differs from divider");
endmodule

// [bench/spims_flash_model.sv]
// Purpose: Behavioural one-line mode-0 serial device on the far side.
// Assumes: Clock idles low; words are 8 bits, most significant bit first.
// Notes: The reply word repeats while select stays low.
`timescale 1ns/1ps
module spims_flash_model (
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Reply and received word
  input wire logic [7:0] reply,
  output logic [7:0] rx_word
);
  logic [7:0] out_q = 8'h00;
  initial
  begin
    miso = 1'b0;
    rx_word = 8'h00;
  end
  always @(negedge cs_n)
  begin
    out_q = reply;
    miso = reply[7];
  end
  always @(posedge sck)
    if (!cs_n)
      rx_word = {rx_word[6:0], mosi};
  always @(negedge sck)
    if (!cs_n)
    begin
      out_q = {out_q[6:0], out_q[7]};
      miso = out_q[7];
    end
  // A released line shows the inverse of its last level.
  always @(posedge cs_n)
    miso = ~miso;
endmodule

// [bench/tb_spims_core.sv]
// Purpose: Self-checking bench of the serial controller in master mode.
// Assumes: Reads are compared by a monitor against queued expectations.
// Notes: Divider 3 gives a half period of four clock cycles.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_spims_core;
  import spims_pkg::*;
  localparam logic [7:0] A_CFG = {IDX_CFG, 2'b00};
  localparam logic [7:0] A_CLK = {IDX_CLK, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STAT, 2'b00};
  localparam logic [7:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [7:0] A_FS = {IDX_FS, 2'b00};
  logic pclk = 0;
  logic presetn = 0;
  logic [7:0] paddr = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, sck_o, sck_oe, cs_n_o, cs_n_oe, irq, fso, miso;
  logic [3:0] dat_o, dat_oe, dat_i;
  logic [7:0] rep = 0, rxw, fs_cap = 0, w1, w2;
  logic [32:0] e;
  logic sck_d = 0;
  logic [32:0] expq[$];
  int err_count = 0, checks = 0, tog = 0, gap = 100, badgap = 0;
  int irq_n = 0, t0, i0;
  always #2 pclk = ~pclk;
  assign dat_i = {dat_o[3:1] ^ ~dat_oe[3:1], miso};
  spims_core i_spims_core (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_i(sck_o & sck_oe), .sck_o(sck_o), .sck_oe(sck_oe),
    .cs_n_i(cs_n_o | ~cs_n_oe), .cs_n_o(cs_n_o), .cs_n_oe(cs_n_oe),
    .dat_i(dat_i), .dat_o(dat_o), .dat_oe(dat_oe),
    .frame_sync_out(fso), .irq(irq));
  spims_flash_model i_spims_flash_model (.sck(sck_o), .cs_n(cs_n_o),
    .mosi(dat_i[1]), .miso(miso), .reply(rep), .rx_word(rxw));
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = expq.pop_front();
      `CHK("prdata", e, {pslverr, prdata})
    end
  end
  always @(posedge pclk)
  begin
    gap <= gap + 1;
    sck_d <= sck_o;
    if (sck_o !== sck_d)
    begin
      tog <= tog + 1;
      gap <= 1;
      if (gap < 8 && gap != 4)
        badgap <= badgap + 1;
    end
    if (irq === 1'b1)
      irq_n <= irq_n + 1;
  end
  always @(posedge sck_o)
    if (cs_n_o === 1'b0)
      fs_cap <= {fs_cap[6:0], fso};
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (n >= 20)
    begin
      err_count++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    expq.push_back(x);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (cs_n_o !== 1'b0 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (cs_n_o !== 1'b0)
      n = 400;
    while (cs_n_o !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    if (n >= 400)
    begin
      err_count++;
      final_report();
    end
  endtask
  initial
  begin
    void'($urandom(32'h8285));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(A_CFG, 33'h0);
    rd(A_CLK, 33'h0);
    rd(A_ST, 33'h0);
    rd(A_FS, 33'h0);
    rd(8'h14, 33'h100000000);
    $display("test reset values done");
    apb(A_CFG, 1'b1, 32'h2f);
    apb(A_CLK, 1'b1, 32'h0c);
    apb(A_FS, 1'b1, 32'hf0);
    rd(A_CFG, 33'h2f);
    rd(A_CLK, 33'h0c);
    `CHK("frame_sync_out idle", 1'b1, fso)
    `CHK("enables", 6'h32, {sck_oe, cs_n_oe, dat_oe})
    apb(A_CFG, 1'b1, 32'ha02f);
    @(posedge pclk);
    `CHK("rx lines", 4'h0, dat_oe)
    apb(A_CFG, 1'b1, 32'h402f);
    @(posedge pclk);
    `CHK("four lines", 4'hf, dat_oe)
    apb(A_CFG, 1'b1, 32'h202f);
    @(posedge pclk);
    `CHK("two lines", 4'h3, dat_oe)
    apb(A_CFG, 1'b1, 32'h2f);
    @(posedge pclk);
    `CHK("one line", 4'h2, dat_oe)
    $display("test configuration done");
    rep <= 8'($urandom);
    w1 = 8'($urandom);
    t0 = tog;
    i0 = irq_n;
    apb(A_DAT, 1'b1, {24'h0, w1});
    wait_done();
    `CHK("model word", w1, rxw)
    `CHK("toggles", 16, tog - t0)
    `CHK("half period", 0, badgap)
    `CHK("frame_sync_out bits", 8'hf0, fs_cap)
    `CHK("irq", 1'b1, irq_n > i0)
    `CHK("frame_sync_out idle", 1'b1, fso)
    rd(A_ST, 33'h08);
    rd(A_DAT, {25'h0, rep});
    rd(A_ST, 33'h0);
    $display("test single word done");
    w1 = 8'($urandom);
    w2 = 8'($urandom);
    t0 = tog;
    apb(A_DAT, 1'b1, {24'h0, w1});
    apb(A_DAT, 1'b1, {24'h0, w2});
    rd(A_ST, 33'h06);
    wait_done();
    `CHK("model word", w2, rxw)
    `CHK("toggles", 32, tog - t0)
    `CHK("frame_sync_out reuse", 8'hf0, fs_cap)
    rd(A_ST, 33'h18);
    rd(A_DAT, {25'h0, rep});
    rd(A_ST, 33'h10);
    apb(A_ST, 1'b1, 32'h10);
    rd(A_ST, 33'h0);
    $display("test back to back done");
    apb(A_DAT, 1'b1, {24'h0, w1});
    apb(A_CFG, 1'b1, 32'h82f);
    rd(A_ST, 33'h0);
    `CHK("select idle", 1'b1, cs_n_o)
    apb(A_CFG, 1'b1, 32'h2f);
    $display("test soft reset done");
    final_report();
  end
endmodule
